// File: logic/sbp_port_defs.vh
`ifndef SBP_PORT_DEFS_VH
`define SBP_PORT_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SBP_OFS_PIN_DATA      8'h05
`define SBP_OFS_OPTION        8'h81
`define SBP_OFS_PIN_DIR       8'h85
`define SBP_OFS_ANALOG_SEL    8'h91
`define SBP_OFS_PULLUP_EN     8'h95
`define SBP_OFS_CHANGE_EN     8'h96
`define SBP_OFS_INT_STATUS    8'hA0
`define SBP_OFS_INT_ENABLE    8'hA1
`define SBP_OFS_INT_CLEAR     8'hA2
`define SBP_OFS_PIN_CTRL      8'hA3
`define SBP_OFS_ALT_FN_EN     8'hA4
`define SBP_OFS_DATA_SET      8'hA5
`define SBP_OFS_DATA_CLR      8'hA6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SBP_BIT_PULLUP_GLOBAL_DISABLE 7
`define SBP_BIT_INPUT_ONLY_PIN        3
`define SBP_BIT_MASTER_CLEAR_ENABLE   0
`define SBP_BIT_PIN_CHANGE_FLAG       0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SBP_RST_OPTION        8'hFF
`define SBP_RST_PIN_DIR       6'h3F
`define SBP_RST_ANALOG_SEL    6'h3F
`define SBP_RST_PULLUP_EN     6'h37
`define SBP_RST_CHANGE_EN     6'h00
`define SBP_RST_LATCH         6'h00
`define SBP_RST_PIN_CTRL      8'h00
`define SBP_RST_ALT_FN_EN     6'h00
`define SBP_RST_INT_ENABLE    1'h0

// ----------------------------------------------------------------------
// masks
// ----------------------------------------------------------------------
`define SBP_PULLUP_CAPABLE    6'h37
`define SBP_INPUT_ONLY_MASK   6'h08

`endif

// File: logic/sbp_pin_sync.v
`default_nettype none

// ----------------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------
module sbp_pin_sync #(
    parameter WIDTH = 6
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             ce,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level_r
);

    reg [WIDTH-1:0] stage1_r;
    reg [WIDTH-1:0] stage2_r;
    reg [WIDTH-1:0] stage3_r;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage1_r[i] <= 1'b0;
                    stage2_r[i] <= 1'b0;
                    stage3_r[i] <= 1'b0;
                    level_r[i]  <= 1'b0;
                end else if (ce) begin
                    stage1_r[i] <= pin_in[i];
                    stage2_r[i] <= stage1_r[i];
                    stage3_r[i] <= stage2_r[i];
                    // change taken once stages two and three agree
                    if (stage2_r[i] == stage3_r[i]) begin
                        level_r[i] <= stage3_r[i];
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// File: logic/sbp_port.v
// The implementer's own choice: the address-and-strobe port.
`default_nettype none

`include "sbp_port_defs.vh"

module sbp_port #(
    parameter PINS = 6
) (
    input  wire            clk,
    input  wire            reset_n,
    input  wire            ce,
    // register port
    input  wire [7:0]      addr,
    input  wire [7:0]      wr_data,
    input  wire            wr_en,
    input  wire            rd_en,
    output reg  [7:0]      rd_data,
    // pins
    input  wire [PINS-1:0] pin_in,
    output reg  [PINS-1:0] pin_out,
    output reg  [PINS-1:0] pin_oe_n,
    output reg  [PINS-1:0] pullup_en,
    // alternate function side
    input  wire [PINS-1:0] alt_out,
    input  wire [PINS-1:0] alt_oe_n,
    // interrupt
    output reg             irq
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    // pins that have a weak pull-up fitted
    localparam [PINS-1:0] PULL_CAP = `SBP_PULLUP_CAPABLE;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg  [PINS-1:0] latch_r;
    reg  [PINS-1:0] latch_nxt;
    reg  [PINS-1:0] dir_r;
    reg  [PINS-1:0] dir_nxt;
    reg  [7:0]      option_r;
    reg  [PINS-1:0] analog_sel_r;
    reg  [PINS-1:0] pullup_bits_r;
    reg  [PINS-1:0] change_en_r;
    reg  [PINS-1:0] change_ref_r;
    reg  [7:0]      pin_ctrl_r;
    reg  [PINS-1:0] alt_fn_en_r;
    reg             change_flag_r;
    reg             change_flag_nxt;
    reg             int_en_r;
    reg  [7:0]      rd_nxt;
    reg             int_en_nxt;
    reg  [PINS-1:0] out_nxt;
    reg  [PINS-1:0] oe_n_nxt;
    reg  [PINS-1:0] pull_nxt;

    wire [PINS-1:0] level;
    wire [PINS-1:0] port_view;
    wire [PINS-1:0] mclr_mask;
    wire            mismatch;
    wire            wr_data_reg;
    wire            wr_set_reg;
    wire            wr_clr_reg;
    wire            rd_data_reg;
    wire            port_touch;

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    sbp_pin_sync #(
        .WIDTH   (PINS)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .pin_in  (pin_in),
        .level_r (level)
    );

    // ------------------------------------------------------------------
    // port view as software reads it
    // ------------------------------------------------------------------
    assign mclr_mask = pin_ctrl_r[`SBP_BIT_MASTER_CLEAR_ENABLE] ?
                       `SBP_INPUT_ONLY_MASK : {PINS{1'b0}};

    assign port_view = level
                       & ~analog_sel_r
                       & ~mclr_mask;

    // ------------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------------
    assign wr_data_reg = wr_en && (addr == `SBP_OFS_PIN_DATA);
    assign wr_set_reg  = wr_en && (addr == `SBP_OFS_DATA_SET);
    assign wr_clr_reg  = wr_en && (addr == `SBP_OFS_DATA_CLR);
    assign rd_data_reg = rd_en && (addr == `SBP_OFS_PIN_DATA);

    // any read or write of the data register ends the mismatch
    assign port_touch = rd_data_reg || wr_data_reg || wr_set_reg || wr_clr_reg;

    // ------------------------------------------------------------------
    // output latch, read-modify-write
    // ------------------------------------------------------------------
    always @* begin
        latch_nxt = latch_r;
        if (wr_data_reg) begin
            latch_nxt = wr_data[PINS-1:0];
        end else if (wr_set_reg) begin
            latch_nxt = port_view | wr_data[PINS-1:0];
        end else if (wr_clr_reg) begin
            latch_nxt = port_view & ~wr_data[PINS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // direction register
    // ------------------------------------------------------------------
    always @* begin
        dir_nxt = dir_r;
        if (wr_en && (addr == `SBP_OFS_PIN_DIR)) begin
            dir_nxt = wr_data[PINS-1:0] | `SBP_INPUT_ONLY_MASK;
        end
    end

    // ------------------------------------------------------------------
    // change detect and sticky flag
    // ------------------------------------------------------------------
    assign mismatch = |(change_en_r & (port_view ^ change_ref_r));

    always @* begin
        change_flag_nxt = change_flag_r;
        if (wr_en && (addr == `SBP_OFS_INT_CLEAR)
            && wr_data[`SBP_BIT_PIN_CHANGE_FLAG]) begin
            change_flag_nxt = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (mismatch) begin
            change_flag_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_r       <= `SBP_RST_LATCH;
            dir_r         <= `SBP_RST_PIN_DIR;
            option_r      <= `SBP_RST_OPTION;
            analog_sel_r  <= `SBP_RST_ANALOG_SEL;
            pullup_bits_r <= `SBP_RST_PULLUP_EN;
            change_en_r   <= `SBP_RST_CHANGE_EN;
            change_ref_r  <= {PINS{1'b0}};
            pin_ctrl_r    <= `SBP_RST_PIN_CTRL;
            alt_fn_en_r   <= `SBP_RST_ALT_FN_EN;
            change_flag_r <= 1'b0;
            int_en_r      <= `SBP_RST_INT_ENABLE;
        end else if (ce) begin
            latch_r       <= latch_nxt;
            dir_r         <= dir_nxt;
            change_flag_r <= change_flag_nxt;
            if (port_touch) begin
                change_ref_r <= port_view;
            end
            if (wr_en) begin
                case (addr)
                    `SBP_OFS_OPTION: begin
                        option_r <= wr_data;
                    end
                    `SBP_OFS_ANALOG_SEL: begin
                        analog_sel_r <= wr_data[PINS-1:0];
                    end
                    `SBP_OFS_PULLUP_EN: begin
                        pullup_bits_r <= wr_data[PINS-1:0]
                                         & `SBP_PULLUP_CAPABLE;
                    end
                    `SBP_OFS_CHANGE_EN: begin
                        change_en_r <= wr_data[PINS-1:0];
                    end
                    `SBP_OFS_INT_ENABLE: begin
                        int_en_r <= wr_data[`SBP_BIT_PIN_CHANGE_FLAG];
                    end
                    `SBP_OFS_PIN_CTRL: begin
                        pin_ctrl_r <= wr_data;
                    end
                    `SBP_OFS_ALT_FN_EN: begin
                        alt_fn_en_r <= wr_data[PINS-1:0];
                    end
                    default: begin
                        option_r <= option_r;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always @* begin
        rd_nxt = 8'h00;
        case (addr)
            `SBP_OFS_PIN_DATA: begin
                rd_nxt = {2'b00, port_view};
            end
            `SBP_OFS_PIN_DIR: begin
                rd_nxt = {2'b00, dir_r | `SBP_INPUT_ONLY_MASK};
            end
            `SBP_OFS_OPTION: begin
                rd_nxt = option_r;
            end
            `SBP_OFS_ANALOG_SEL: begin
                rd_nxt = {2'b00, analog_sel_r};
            end
            `SBP_OFS_PULLUP_EN: begin
                rd_nxt = {2'b00, pullup_bits_r};
            end
            `SBP_OFS_CHANGE_EN: begin
                rd_nxt = {2'b00, change_en_r};
            end
            `SBP_OFS_INT_STATUS: begin
                rd_nxt = {7'h00, change_flag_r};
            end
            `SBP_OFS_INT_ENABLE: begin
                rd_nxt = {7'h00, int_en_r};
            end
            `SBP_OFS_PIN_CTRL: begin
                rd_nxt = pin_ctrl_r;
            end
            `SBP_OFS_ALT_FN_EN: begin
                rd_nxt = {2'b00, alt_fn_en_r};
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= rd_en ? rd_nxt : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // interrupt enable, next value
    // ------------------------------------------------------------------
    // irq follows an enable write at the same edge as the register
    always @* begin
        int_en_nxt = int_en_r;
        if (wr_en && (addr == `SBP_OFS_INT_ENABLE)) begin
            int_en_nxt = wr_data[`SBP_BIT_PIN_CHANGE_FLAG];
        end
    end

    // ------------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= change_flag_nxt & int_en_nxt;
        end
    end

    // ------------------------------------------------------------------
    // per-pin driver and pull-up
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < PINS; i = i + 1) begin : g_pin
            always @* begin
                if (i == `SBP_BIT_INPUT_ONLY_PIN) begin
                    out_nxt[i]  = 1'b0;
                    oe_n_nxt[i] = 1'b1;
                end else if (alt_fn_en_r[i]) begin
                    out_nxt[i]  = alt_out[i];
                    oe_n_nxt[i] = alt_oe_n[i];
                end else begin
                    out_nxt[i]  = latch_nxt[i];
                    oe_n_nxt[i] = dir_nxt[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // pull-up request
    // ------------------------------------------------------------------
    // off while the pin is driven, by the latch or an alternate function
    always @* begin
        pull_nxt = {PINS{1'b0}};
        if (!option_r[`SBP_BIT_PULLUP_GLOBAL_DISABLE]) begin
            pull_nxt = pullup_bits_r
                       & oe_n_nxt
                       & PULL_CAP;
        end
    end

    // ------------------------------------------------------------------
    // pin flops
    // ------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out   <= {PINS{1'b0}};
            pin_oe_n  <= {PINS{1'b1}};
            pullup_en <= {PINS{1'b0}};
        end else if (ce) begin
            pin_out   <= out_nxt;
            pin_oe_n  <= oe_n_nxt;
            pullup_en <= pull_nxt;
        end
    end

endmodule

`default_nettype wire

// File: testbench/sbp_port_asserts.sv
`default_nettype none
`include "sbp_port_defs.vh"
module sbp_port_asserts #(
    parameter PINS = 6
) (
    input wire logic            clk,
    input wire logic            reset_n,
    input wire logic            ce,
    input wire logic [7:0]      addr,
    input wire logic [7:0]      wr_data,
    input wire logic            wr_en,
    input wire logic            rd_en,
    input wire logic [7:0]      rd_data,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n,
    input wire logic [PINS-1:0] pullup_en,
    input wire logic            irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PINS-1:0] alt_r;
    wire             irq_wr = wr_en && (addr == `SBP_OFS_INT_CLEAR
                                        || addr == `SBP_OFS_INT_ENABLE);
    wire             dir_wr = ce && wr_en && addr == `SBP_OFS_PIN_DIR;
    wire             dat_wr = ce && wr_en && addr == `SBP_OFS_PIN_DATA;
    wire             dir_rd = ce && rd_en && addr == `SBP_OFS_PIN_DIR;
    wire             port_rd = dir_rd || (ce && rd_en && addr == `SBP_OFS_PIN_DATA);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // alternate owned pins are exempt from latch and direction checks
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_r <= '0;
        end else if (ce && wr_en && addr == `SBP_OFS_ALT_FN_EN) begin
            alt_r <= wr_data[PINS-1:0];
        end
    end
    property p_pin3_hiz;
        pin_oe_n[`SBP_BIT_INPUT_ONLY_PIN];
    endproperty
    a_pin3_hiz: assert property (p_pin3_hiz) else $error("pin three driven");
    property p_pin3_nopull;
        !pullup_en[`SBP_BIT_INPUT_ONLY_PIN];
    endproperty
    a_pin3_nopull: assert property (p_pin3_nopull) else $error("pin three pull-up");
    property p_pull_off_out;
        (pullup_en & ~pin_oe_n) == '0;
    endproperty
    a_pull_off_out: assert property (p_pull_off_out) else $error("pull-up on output");
    property p_dir_drive;
        dir_wr |=> (({2'b00, pin_oe_n} ^ ($past(wr_data) | 8'h08)) & {2'b00, ~alt_r}) == 8'h00;
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("driver not per direction");
    property p_out_latch;
        dat_wr |=> (({2'b00, pin_out} ^ $past(wr_data)) & {2'b00, ~alt_r & ~pin_oe_n}) == 8'h00;
    endproperty
    a_out_latch: assert property (p_out_latch) else $error("pin not from latch");
    property p_rd_once;
        ce && !rd_en |=> rd_data == 8'h00;
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data lingers");
    property p_port_hi_zero;
        port_rd |=> rd_data[7:6] == 2'b00;
    endproperty
    a_port_hi_zero: assert property (p_port_hi_zero) else $error("upper bits set");
    property p_dir3_one;
        dir_rd |=> rd_data[`SBP_BIT_INPUT_ONLY_PIN];
    endproperty
    a_dir3_one: assert property (p_dir3_one) else $error("direction bit three low");
    property p_irq_fall;
        $fell(irq) |-> $past(irq_wr);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    c_irq_rise: cover property ($rose(irq));
    c_irq_clear: cover property (irq_wr ##1 !irq);
    c_port_rd: cover property (port_rd);
endmodule
bind sbp_port sbp_port_asserts #(.PINS(PINS)) u_chk (.clk, .reset_n, .ce, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data, .pin_out, .pin_oe_n, .pullup_en, .irq);
`default_nettype wire

// File: testbench/sbp_pin_model.sv
`default_nettype none
module sbp_pin_model (
    input  wire logic       clk,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe_n,
    input  wire logic [5:0] pullup_en,
    input  wire logic [5:0] ext_val,
    input  wire logic [5:0] ext_en,
    output logic      [5:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] last_r = 6'h00;
    logic [5:0] float_lvl;
    // undriven pin without pull-up wanders away from its last level
    assign float_lvl = pullup_en | ~last_r;
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                  | (pin_oe_n & ~ext_en & float_lvl);
    always @(posedge clk) last_r <= pin_in;
endmodule
`default_nettype wire

// File: testbench/sbp_port_tb.sv
`default_nettype none
module sbp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] RA [9] = '{8'h81, 8'h85, 8'h91, 8'h95, 8'h96, 8'hA0, 8'hA1, 8'hA3, 8'h40};
    localparam logic [7:0] RV [9] = '{8'hFF, 8'h3F, 8'h3F, 8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] OPS [3] = '{8'h05, 8'hA5, 8'hA6};
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [5:0]  ext_val = 6'h00;
    logic [5:0]  ext_en = 6'h3F;
    logic [5:0]  alt_out = 6'h00;
    logic [5:0]  alt_oe_n = 6'h3F;
    wire  [7:0]  rd_data;
    wire  [5:0]  pin_in, pin_out, pin_oe_n, pullup_en;
    wire         irq;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cyc = 0;
    logic [31:0] seed = 32'h7AC4ECE1;
    logic [5:0]  m_lat, m_dir, m_ana, m_pue, m_view;
    logic        m_opt7, m_mclr;
    logic [7:0]  d;
    always #25 clk = ~clk;
    sbp_port #(.PINS(6)) dut (.clk, .reset_n, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .pin_in, .pin_out, .pin_oe_n, .pullup_en, .alt_out, .alt_oe_n, .irq);
    sbp_pin_model u_pins (.clk, .pin_out, .pin_oe_n, .pullup_en, .ext_val, .ext_en, .pin_in);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [5:0] view();
        logic [5:0] drv;
        drv = ~(m_dir | 6'h08);
        return ((m_lat & drv) | (ext_val & ~drv)) & ~m_ana & ~(m_mclr ? 6'h08 : 6'h00);
    endfunction
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rd_data;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        chk({2'b00, pin_oe_n}, 8'h3F);
        chk({2'b00, pullup_en}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            rchk(RA[i], RV[i]);
        end
        m_lat = 6'h00;
        for (int n = 0; n < 40; n++) begin
            m_ana = 6'(xs() & xs() & xs());
            m_dir = 6'(xs()) | m_ana;
            d = 8'(xs());
            m_opt7 = d[7];
            m_pue = 6'(xs());
            m_mclr = 1'(xs());
            wr(8'h91, {2'b00, m_ana});
            wr(8'h85, {2'b00, m_dir});
            wr(8'h81, d);
            wr(8'h95, {2'b00, m_pue});
            wr(8'hA3, {7'h00, m_mclr});
            ext_val <= 6'(xs());
            alt_out <= 6'(xs());
            alt_oe_n <= 6'(xs());
            repeat (6) @(posedge clk);
            d = 8'(xs());
            m_view = view();
            wr(OPS[n % 3], d);
            m_lat = n % 3 == 0 ? d[5:0] : n % 3 == 1 ? m_view | d[5:0] : m_view & ~d[5:0];
            repeat (6) @(posedge clk);
            chk({2'b00, pin_oe_n}, {2'b00, m_dir | 6'h08});
            chk({2'b00, pin_out & ~pin_oe_n}, {2'b00, m_lat & ~(m_dir | 6'h08)});
            chk({2'b00, pullup_en}, {2'b00, m_opt7 ? 6'h00 : m_pue & m_dir & 6'h37});
            rchk(8'h05, {2'b00, view()});
            rchk(8'h85, {2'b00, m_dir | 6'h08});
            rchk(8'h95, {2'b00, m_pue & 6'h37});
        end
        wr(8'h91, 8'h00);
        wr(8'hA3, 8'h00);
        wr(8'h85, 8'h3F);
        wr(8'h96, 8'h3F);
        wr(8'hA1, 8'h01);
        ext_val <= 6'h00;
        repeat (6) @(posedge clk);
        rd(8'h05, d);
        wr(8'hA2, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        ext_val <= 6'h08;
        repeat (6) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        rchk(8'hA0, 8'h01);
        wr(8'hA2, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        rd(8'h05, d);
        wr(8'hA2, 8'h01);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        wr(8'hA1, 8'h00);
        ext_val <= 6'h28;
        repeat (6) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        rchk(8'hA0, 8'h01);
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h85, 8'h00);
        ce <= 1'b1;
        rchk(8'h85, 8'h3F);
        alt_out <= 6'h01;
        alt_oe_n <= 6'h3E;
        wr(8'hA4, 8'h01);
        repeat (2) @(posedge clk);
        chk({6'h00, pin_oe_n[0], pin_out[0]}, 8'h01);
        test_done();
    end
endmodule
`default_nettype wire
